// ===== owr_pkg.sv
// constants, field layout and carrier types for the single-wire led chain host
// assumes a 250 MHz system clock; shared by the host, its word fifo, the driver model and the bench
`default_nettype none

package owr_pkg;

  // clock and bit period limits
  localparam int CLK_MHZ            = 250;
  localparam int NS_PER_US          = 1000;
  localparam int BIT_PERIOD_MIN_NS  = 330;
  localparam int BIT_PERIOD_MAX_NS  = 10000;
  localparam int BIT_PERIOD_MIN_CYC = (BIT_PERIOD_MIN_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int BIT_PERIOD_MAX_CYC = (BIT_PERIOD_MAX_NS * CLK_MHZ) / NS_PER_US;
  localparam int CNT_W              = 12;

  // pulse shaping inside one bit slot, as right shifts of the period
  localparam int PULSE_SHIFT        = 3;
  localparam int SECOND_SHIFT       = 2;

  // device low-time thresholds, and what the host actually holds
  localparam int DEV_EOS_HALF_PERIODS = 7;
  localparam int DEV_LATCH_PERIODS    = 8;
  localparam int EOS_HOLD_PERIODS     = 5;
  localparam int LATCH_HOLD_PERIODS   = 12;
  localparam int HOLD_W               = 6;

  // packet layout
  localparam int          LEVEL_W   = 12;
  localparam int          PKT_W     = 48;
  localparam int          BIT_IDX_W = 6;
  localparam int          MEAS_BITS = 2;
  localparam int          KEY_LSB   = 36;
  localparam int          CH0_LSB   = 24;
  localparam int          CH1_LSB   = 12;
  localparam int          CH2_LSB   = 0;
  localparam logic [11:0] WRITE_KEY = 12'h3aa;
  localparam int          CHAIN_W   = 8;

  // three levels travel as one word, ch0 in the top bits
  typedef struct packed {
    logic [LEVEL_W-1:0] ch0;
    logic [LEVEL_W-1:0] ch1;
    logic [LEVEL_W-1:0] ch2;
  } owr_level_word_type;

  typedef struct packed {
    logic busy;
    logic frame_done;
    logic underrun;
  } owr_status_type;

  typedef enum logic [1:0] {
    OWR_IDLE,
    OWR_BIT,
    OWR_HOLD
  } owr_state_type;

endpackage

`default_nettype wire

// ===== owr_fifo.sv
// word fifo in front of the serial line encoder
// assumes one clock; the drain side may stall for whole packets
`default_nettype none
`timescale 1ns/100ps

module owr_fifo
  import owr_pkg::*;
#(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  // fill side
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  input  wire logic [WIDTH-1:0]           in_data_i,
  // drain side
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic [WIDTH-1:0]                out_data_o,
  output logic [$clog2(DEPTH+1)-1:0]      fill_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int FW = $clog2(DEPTH+1);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  localparam logic [FW-1:0] FULL_FILL = FW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [FW-1:0]    fill_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (fill_reg != FULL_FILL);
  assign out_valid_o = (fill_reg != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign fill_o      = fill_reg;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg   <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        fill_reg <= fill_reg + 1'b1;
      end else if (pop && !push) begin
        fill_reg <= fill_reg - 1'b1;
      end
    end
  end

endmodule // owr_fifo

`default_nettype wire

// ===== owr_chain_host.sv
// host that writes level words to a chain of single-wire led drivers
// assumes the chain listens on serial_line_in_o; one word per device per frame
`default_nettype none
`timescale 1ns/100ps

module owr_chain_host
  import owr_pkg::*;
#(
  parameter int BIT_PERIOD_NS  = 1000,
  parameter int FIFO_DEPTH     = 8,
  parameter int EOS_PERIODS    = EOS_HOLD_PERIODS,
  parameter int LATCH_PERIODS  = LATCH_HOLD_PERIODS
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // level words, one per device, first device first
  input  wire owr_level_word_type word_i,
  input  wire logic               word_valid_i,
  output logic                    word_ready_o,
  // number of devices in the chain
  input  wire logic [CHAIN_W-1:0] chain_len_i,
  // serial line to the first device
  output logic                    serial_line_in_o,
  // status
  output owr_status_type          status_o
);

  localparam int BIT_CYC    = (BIT_PERIOD_NS * CLK_MHZ) / NS_PER_US;
  localparam int PULSE_CYC  = BIT_CYC >> PULSE_SHIFT;
  localparam int SECOND_CYC = BIT_CYC >> SECOND_SHIFT;
  localparam int FW         = $clog2(FIFO_DEPTH + 1);

  localparam logic [CNT_W-1:0]     LAST_CYC_C   = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0]     PULSE_C      = CNT_W'(PULSE_CYC);
  localparam logic [CNT_W-1:0]     SECOND_C     = CNT_W'(SECOND_CYC);
  localparam logic [CNT_W-1:0]     SECOND_END_C = CNT_W'(SECOND_CYC + PULSE_CYC);
  localparam logic [HOLD_W-1:0]    EOS_LAST_C   = HOLD_W'(EOS_PERIODS - 1);
  localparam logic [HOLD_W-1:0]    LATCH_LAST_C = HOLD_W'(LATCH_PERIODS - 1);
  localparam logic [BIT_IDX_W-1:0] LAST_BIT_C   = BIT_IDX_W'(PKT_W - 1);
  localparam logic [BIT_IDX_W-1:0] MEAS_BITS_C  = BIT_IDX_W'(MEAS_BITS);
  localparam logic [FW-1:0]        DEPTH_C      = FW'(FIFO_DEPTH);

  owr_state_type      state_reg;
  logic [CNT_W-1:0]   cnt_reg;
  logic [HOLD_W-1:0]  hold_reg;
  logic [BIT_IDX_W-1:0] bit_idx_reg;
  logic [PKT_W-1:0]   pkt_reg;
  logic [PKT_W-1:0]   pkt_next;
  logic [CHAIN_W-1:0] pkt_cnt_reg;
  logic               is_latch_reg;
  logic               line_reg;
  logic               line_next;
  logic               done_reg;
  logic               underrun_reg;

  owr_level_word_type fifo_word;
  logic               fifo_valid;
  logic               fifo_pop;
  logic [FW-1:0]      fifo_fill;
  logic [CHAIN_W-1:0] chain_len;
  logic [FW-1:0]      need_words;
  logic               slot_end;
  logic               pkt_end;
  logic               hold_end;
  logic               frame_last;

  owr_fifo #(
    .WIDTH ($bits(owr_level_word_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (word_valid_i),
    .in_ready_o  (word_ready_o),
    .in_data_i   (word_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_word),
    .fill_o      (fifo_fill)
  );

  // a chain length of zero is taken as one device
  assign chain_len = (chain_len_i == '0) ? CHAIN_W'(1) : chain_len_i;

  // frame waits until the fifo holds the whole chain, or is full
  assign need_words = (chain_len >= CHAIN_W'(FIFO_DEPTH)) ? DEPTH_C : FW'(chain_len);

  assign slot_end   = (cnt_reg == LAST_CYC_C);
  assign pkt_end    = (state_reg == OWR_BIT) && slot_end && (bit_idx_reg == LAST_BIT_C);
  assign hold_end   = (state_reg == OWR_HOLD) && slot_end
                   && (hold_reg == (is_latch_reg ? LATCH_LAST_C : EOS_LAST_C));
  assign frame_last = (pkt_cnt_reg == chain_len);

  // a new packet is taken at frame start or after a packet end hold
  assign fifo_pop = fifo_valid
                 && (((state_reg == OWR_IDLE) && (fifo_fill >= need_words))
                  || (hold_end && !is_latch_reg));

  // key on top, then ch0, ch1, ch2 down to bit zero
  assign pkt_next = {WRITE_KEY, fifo_word.ch0, fifo_word.ch1, fifo_word.ch2};

  // every slot starts with a rising edge; a one adds a second early edge
  always_comb begin
    line_next = 1'b0;
    if (state_reg == OWR_BIT) begin
      if (cnt_reg < PULSE_C) begin
        line_next = 1'b1;
      end else if (pkt_reg[PKT_W-1] && (cnt_reg >= SECOND_C) && (cnt_reg < SECOND_END_C)) begin
        line_next = 1'b1;
      end
    end
  end

  // sequencing: slots, packets and holds
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg    <= OWR_IDLE;
      cnt_reg      <= '0;
      hold_reg     <= '0;
      bit_idx_reg  <= '0;
      is_latch_reg <= 1'b0;
    end else begin
      case (state_reg)
        OWR_IDLE: begin
          cnt_reg     <= '0;
          hold_reg    <= '0;
          bit_idx_reg <= '0;
          if (fifo_pop) begin
            state_reg <= OWR_BIT;
          end
        end
        OWR_BIT: begin
          cnt_reg <= slot_end ? '0 : cnt_reg + 1'b1;
          if (pkt_end) begin
            // latch once the chain is served, or when words ran out
            state_reg    <= OWR_HOLD;
            is_latch_reg <= frame_last || !fifo_valid;
            hold_reg     <= '0;
          end else if (slot_end) begin
            bit_idx_reg <= bit_idx_reg + 1'b1;
          end
        end
        OWR_HOLD: begin
          cnt_reg <= slot_end ? '0 : cnt_reg + 1'b1;
          if (slot_end) begin
            hold_reg <= hold_reg + 1'b1;
          end
          if (hold_end) begin
            bit_idx_reg <= '0;
            hold_reg    <= '0;
            state_reg   <= is_latch_reg ? OWR_IDLE : OWR_BIT;
          end
        end
        default: begin
          state_reg <= OWR_IDLE;
        end
      endcase
    end
  end

  // packet shifter, msb leaves first
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pkt_reg <= '0;
    end else if (fifo_pop) begin
      pkt_reg <= pkt_next;
    end else if ((state_reg == OWR_BIT) && slot_end) begin
      pkt_reg <= {pkt_reg[PKT_W-2:0], 1'b0};
    end
  end

  // packets sent in the current frame
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pkt_cnt_reg <= '0;
    end else if (hold_end && is_latch_reg) begin
      pkt_cnt_reg <= '0;
    end else if (fifo_pop) begin
      pkt_cnt_reg <= pkt_cnt_reg + 1'b1;
    end
  end

  // line driver, low at rest and during holds
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_reg <= 1'b0;
    end else begin
      line_reg <= line_next;
    end
  end

  // frame end pulses
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_reg     <= 1'b0;
      underrun_reg <= 1'b0;
    end else begin
      done_reg     <= hold_end && is_latch_reg;
      underrun_reg <= hold_end && is_latch_reg && !frame_last;
    end
  end

  assign serial_line_in_o    = line_reg;
  assign status_o.busy       = (state_reg != OWR_IDLE);
  assign status_o.frame_done = done_reg;
  assign status_o.underrun   = underrun_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_period_range: assert property (
    (BIT_CYC >= BIT_PERIOD_MIN_CYC) && (BIT_CYC <= BIT_PERIOD_MAX_CYC))
    else $error("bit period outside the allowed range");

  a_slot_rising_edge: assert property (
    (state_reg == OWR_BIT) && (cnt_reg == '0) |=> $rose(serial_line_in_o))
    else $error("bit slot did not open with a rising edge");

  a_zero_stays_low: assert property (
    (state_reg == OWR_BIT) && !pkt_reg[PKT_W-1] && (cnt_reg >= PULSE_C)
    |=> !serial_line_in_o)
    else $error("zero bit shows a second pulse");

  a_one_early_edge: assert property (
    (state_reg == OWR_BIT) && pkt_reg[PKT_W-1] && (cnt_reg == SECOND_C)
    |=> $rose(serial_line_in_o) && (SECOND_CYC * 2 < BIT_CYC))
    else $error("one bit lacks an early second edge");

  a_measure_zeros: assert property (
    (state_reg == OWR_BIT) && (bit_idx_reg < MEAS_BITS_C) |-> !pkt_reg[PKT_W-1])
    else $error("measurement bits are not zero");

  a_packet_length: assert property (
    (state_reg == OWR_BIT) ##1 (state_reg == OWR_HOLD)
    |-> $past(bit_idx_reg) == LAST_BIT_C)
    else $error("packet did not carry 48 bits");

  a_hold_low: assert property (
    (state_reg == OWR_HOLD) && $past(state_reg == OWR_HOLD) |-> !serial_line_in_o)
    else $error("line not low during a hold");

  a_key_on_load: assert property (
    fifo_pop |=> (pkt_reg[PKT_W-1:KEY_LSB] == WRITE_KEY)
             && (pkt_reg[CH1_LSB +: LEVEL_W] == $past(fifo_word.ch1)))
    else $error("packet loaded without the write key");

  a_hold_lengths: assert property (
    hold_end |-> (is_latch_reg ? (LATCH_PERIODS >= DEV_LATCH_PERIODS + 1)
                               : (EOS_PERIODS * 2 > DEV_EOS_HALF_PERIODS)
                                 && (EOS_PERIODS < DEV_LATCH_PERIODS - 1)))
    else $error("hold does not clear the device thresholds");

  a_latch_after_all: assert property (
    pkt_end && frame_last |=> is_latch_reg && (state_reg == OWR_HOLD))
    else $error("latch hold missing after the last packet");

  a_next_packet: assert property (
    pkt_end && !frame_last && fifo_valid |=> !is_latch_reg && (state_reg == OWR_HOLD))
    else $error("packet end hold missing between chain packets");

  a_idle_line_low: assert property (
    (state_reg == OWR_IDLE) && $past(state_reg == OWR_IDLE) |-> !serial_line_in_o)
    else $error("line not low while idle");

  a_one_pulse_ends: assert property (
    (state_reg == OWR_BIT) && pkt_reg[PKT_W-1] && (cnt_reg == SECOND_END_C)
    |=> !serial_line_in_o)
    else $error("second pulse of a one bit did not end");

  a_slot_length: assert property (
    (state_reg != OWR_IDLE) |-> (cnt_reg <= LAST_CYC_C))
    else $error("bit slot longer than the bit period");

  a_underrun_flag: assert property (
    status_o.underrun |-> status_o.frame_done)
    else $error("underrun without a frame end");

endmodule // owr_chain_host

`default_nettype wire

// ===== owr_dev_model.sv
// behavioural model of one chained led driver on the single-wire line
// assumes it is clocked by the system clock, which also serves as its level clock
`timescale 1ns/100ps
`default_nettype none

module owr_dev_model
  import owr_pkg::*;
(
  // clock and power-up reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  // serial line in and forwarded line out
  input  wire logic                 line_i,
  output logic                      line_o,
  // observed state
  output logic [3*LEVEL_W-1:0]      latch_o,
  output var int                    period_o,
  output logic [2:0]                sink_o,
  output logic                      bad_o
);
  logic [PKT_W-1:0]   sr_reg;
  logic [1:0]         phase_reg;
  logic               line_reg;
  logic               pend_reg;
  logic               val_reg;
  logic               frozen_reg;
  int                 since_reg;
  int                 low_reg;
  logic [LEVEL_W-1:0] cnt_reg;
  wire logic          rise = line_i && !line_reg;

  assign line_o = frozen_reg && line_i;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sr_reg <= '0;
      phase_reg <= 2'h0;
      line_reg <= 1'b0;
      pend_reg <= 1'b0;
      val_reg <= 1'b0;
      frozen_reg <= 1'b0;
      since_reg <= 0;
      low_reg <= 0;
      cnt_reg <= '0;
      period_o <= 0;
      latch_o <= '0;
      bad_o <= 1'b0;
    end else begin
      line_reg <= line_i;
      since_reg <= since_reg + 1;
      low_reg <= line_i ? 0 : low_reg + 1;
      cnt_reg <= cnt_reg + 12'h001;
      if (frozen_reg) begin
        // forwarding only
      end else if (rise && phase_reg == 2'h0) begin
        phase_reg <= 2'h1;
        since_reg <= 0;
      end else if (rise && phase_reg == 2'h1) begin
        // since_reg trails the edge spacing by one cycle
        period_o <= since_reg + 1;
        sr_reg <= {sr_reg[PKT_W-3:0], 2'b00};
        phase_reg <= 2'h2;
        since_reg <= 0;
        if (since_reg + 1 < BIT_PERIOD_MIN_CYC || since_reg + 1 > BIT_PERIOD_MAX_CYC) begin
          bad_o <= 1'b1;
        end
      end else if (rise) begin
        if (since_reg * 10 >= period_o * 9) begin
          if (pend_reg) sr_reg <= {sr_reg[PKT_W-2:0], val_reg};
          pend_reg <= 1'b1;
          val_reg <= 1'b0;
          since_reg <= 0;
        end else if (pend_reg && !val_reg && since_reg * 2 < period_o) begin
          val_reg <= 1'b1;
        end else begin
          bad_o <= 1'b1;
        end
      end
      // short low hold: take the last bit and freeze
      if (!frozen_reg && phase_reg == 2'h2 && low_reg == period_o * DEV_EOS_HALF_PERIODS / 2) begin
        if (pend_reg) sr_reg <= {sr_reg[PKT_W-2:0], val_reg};
        pend_reg <= 1'b0;
        frozen_reg <= 1'b1;
      end
      // long low hold: latch on a good key, then time the next packet again
      if (phase_reg == 2'h2 && low_reg == period_o * DEV_LATCH_PERIODS) begin
        if (sr_reg[PKT_W-1:KEY_LSB] == WRITE_KEY) begin
          latch_o <= sr_reg[KEY_LSB-1:0];
          cnt_reg <= '0;
        end
        phase_reg <= 2'h0;
        frozen_reg <= 1'b0;
        pend_reg <= 1'b0;
      end
    end
  end

  for (genvar c = 0; c < 3; c++) begin : g_sink
    wire logic [LEVEL_W-1:0] lvl = latch_o[LEVEL_W*(2-c) +: LEVEL_W];
    assign sink_o[c] = (lvl != '0) && (cnt_reg != '0) && (cnt_reg <= lvl);
  end
endmodule // owr_dev_model

`default_nettype wire

// ===== tb.sv
// self-checking bench: host driving a chain of two modelled drivers
// assumes the host's fifo of 8 words and a 100-cycle bit period
`timescale 1ns/100ps
`default_nettype none

module tb;
  import owr_pkg::*;
  localparam int BIT_NS = 400;
  localparam int T      = BIT_NS * CLK_MHZ / NS_PER_US;

  logic               clk_i = 1'b0;
  logic               rst_b_i = 1'b0;
  logic               word_valid_i = 1'b0;
  owr_level_word_type word_i = '0;
  logic [CHAIN_W-1:0] chain_len_i = 8'h02;
  logic               word_ready_o;
  logic               serial_line_in_o;
  logic               mid_line;
  owr_status_type     status_o;
  logic [35:0]        lat0;
  logic [35:0]        lat1;
  int                 per0;
  int                 per1;
  logic [2:0]         sink0;
  logic [2:0]         sink1;
  logic               bad0;
  logic               bad1;
  int                 miscompares = 0;
  int                 tests_run = 0;
  int                 seed = 94;

  always #2 clk_i = ~clk_i;

  owr_chain_host #(.BIT_PERIOD_NS(BIT_NS)) owr_chain_host_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .word_i(word_i), .word_valid_i(word_valid_i),
    .word_ready_o(word_ready_o), .chain_len_i(chain_len_i),
    .serial_line_in_o(serial_line_in_o), .status_o(status_o));
  owr_dev_model dev0_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .line_i(serial_line_in_o),
    .line_o(mid_line), .latch_o(lat0), .period_o(per0), .sink_o(sink0), .bad_o(bad0));
  owr_dev_model dev1_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .line_i(mid_line),
    .line_o(), .latch_o(lat1), .period_o(per1), .sink_o(sink1), .bad_o(bad1));

  task automatic stop_test();
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic owr_level_word_type rnd();
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    return r[35:0];
  endfunction

  // latched levels a driver should hold for a word
  function automatic logic [35:0] levels(input owr_level_word_type w);
    return {w.ch0, w.ch1, w.ch2};
  endfunction

  task automatic push(input owr_level_word_type w, input logic refuse);
    int n;
    n = 0;
    @(posedge clk_i);
    word_i <= w;
    word_valid_i <= 1'b1;
    @(negedge clk_i);
    while (!refuse && word_ready_o !== 1'b1 && n < 20000) begin
      @(negedge clk_i);
      n++;
    end
    check(36'(word_ready_o), 36'(!refuse), "push ready");
    @(posedge clk_i);
    word_valid_i <= 1'b0;
  endtask

  task automatic wait_frame(input logic under);
    int n;
    n = 0;
    repeat (2) @(negedge clk_i);
    check(36'(status_o.busy), 36'h1, "busy during frame");
    do begin
      @(negedge clk_i);
      n++;
    end while (status_o.frame_done !== 1'b1 && n < 60000);
    check(36'(n < 60000), 36'h1, "frame end");
    check(36'(status_o.underrun), 36'(under), "underrun flag");
    @(negedge clk_i);
    check(36'({status_o, word_ready_o}), 36'h1, "idle after frame");
  endtask

  task automatic check_devs(input owr_level_word_type w0, input owr_level_word_type w1);
    check(lat0, levels(w0), "first driver levels");
    check(lat1, levels(w1), "second driver levels");
    check(36'(per0), 36'(T), "first driver period");
    check(36'(per1), 36'(T), "second driver period");
    check(36'({bad0, bad1}), 36'h0, "bit shapes");
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    stop_test();
  end

  initial begin
    owr_level_word_type w[10];
    @(negedge clk_i);
    check(36'({serial_line_in_o, status_o, word_ready_o, sink0, sink1}), 36'h040, "reset");
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      w[0] = (f == 0) ? 36'hfff000001 : rnd();
      w[1] = (f == 0) ? 36'h800fff000 : rnd();
      for (int i = 0; i < 2; i++) push(w[i], 1'b0);
      wait_frame(1'b0);
      check_devs(w[0], w[1]);
    end
    @(posedge clk_i);
    chain_len_i <= 8'h00;
    w[2] = rnd();
    push(w[2], 1'b0);
    wait_frame(1'b0);
    check_devs(w[2], w[1]);
    @(posedge clk_i);
    chain_len_i <= 8'h0a;
    for (int i = 0; i < 9; i++) begin
      w[i] = rnd();
      push(w[i], 1'b0);
    end
    push(36'h5a5a5a5a5, 1'b1);
    wait_frame(1'b1);
    check_devs(w[0], w[1]);
    @(posedge clk_i);
    chain_len_i <= 8'h02;
    w[0] = rnd();
    w[1] = rnd();
    push(w[0], 1'b0);
    push(w[1], 1'b0);
    wait_frame(1'b0);
    check_devs(w[0], w[1]);
    stop_test();
  end
endmodule // tb

`default_nettype wire
